// [shared/nsaor_pkg.sv]
/*
 * Constants for the neighbour and address-resolution offload responder:
 * register map, control bit positions, reset values and protocol values.
 * Assumes byte addresses on an 8-bit register port, one 32-bit word each.
 */
package nsaor_pkg;
	// --------------------------------------------------------------
	// Register map
	// --------------------------------------------------------------
	localparam int unsigned NSAOR_AW = 8;
	localparam logic [7:0] NSAOR_NBR_LAST = 8'h7C; // Two sets x four addresses x four words
	localparam logic [7:0] NSAOR_SPA_ADDR = 8'h80;
	localparam logic [7:0] NSAOR_TPA_ADDR = 8'h84;
	localparam logic [7:0] NSAOR_WAKE2_ADDR = 8'h88;
	localparam logic [7:0] NSAOR_PMT_ADDR = 8'h8C;
	localparam logic [31:0] NSAOR_RST_WORD = 32'h0000_0000;
	// Bits of wake_ctrl_status_two and power_mgmt_control
	localparam int unsigned NSAOR_B_NBR_EN = 0;
	localparam int unsigned NSAOR_B_ARP_EN = 1;
	localparam int unsigned NSAOR_B_SRC_SEL = 2;
	localparam int unsigned NSAOR_B_NBR_SEEN = 8;
	localparam int unsigned NSAOR_B_ARP_SEEN = 9;
	localparam int unsigned NSAOR_B_RES_CLR = 0;
	// --------------------------------------------------------------
	// Protocol values
	// --------------------------------------------------------------
	localparam logic [15:0] NSAOR_ET_IPV6 = 16'h86DD;
	localparam logic [15:0] NSAOR_ET_ARP = 16'h0806;
	localparam logic [7:0] NSAOR_NH_ICMP6 = 8'h3A;
	localparam logic [7:0] NSAOR_ICMP_NS = 8'h87;
	localparam logic [7:0] NSAOR_ICMP_NA = 8'h88;
	localparam logic [7:0] NSAOR_HOP_MAX = 8'hFF;
	localparam logic [103:0] NSAOR_SNM_PREFIX = 104'hFF02_0000_0000_0000_0000_0001_FF;
	localparam logic [127:0] NSAOR_ALL_NODES = 128'hFF02_0000_0000_0000_0000_0000_0000_0001;
	localparam logic [15:0] NSAOR_NA_LEN = 16'h0020;
	localparam logic [15:0] NSAOR_OPT_TLLA = 16'h0201;
	localparam logic [15:0] NSAOR_ARP_HTYPE = 16'h0001;
	localparam logic [15:0] NSAOR_ARP_PTYPE = 16'h0800;
	localparam logic [7:0] NSAOR_ARP_HLEN = 8'h06;
	localparam logic [7:0] NSAOR_ARP_PLEN = 8'h04;
	localparam logic [15:0] NSAOR_ARP_OP_REQ = 16'h0001;
	localparam logic [15:0] NSAOR_ARP_OP_REP = 16'h0002;
	localparam int unsigned NSAOR_MC_BIT = 40;
endpackage

// [verilog/nsaor_responder.sv]
/*
 * Offload responder: watches frame summaries from the receive parser and
 * queues neighbour advertisement and address-resolution replies for the
 * transmitter; holds its own match and control registers.
 * Assumes the parser and transmitter run on MCLK and the transmitter
 * only takes a reply between frames.
 */
module nsaor_responder
	import nsaor_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic [nsaor_pkg::NSAOR_AW-1:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WE,
	input wire logic RE,
	output logic [31:0] RDATA,
	input wire logic SUSPEND,
	input wire logic [47:0] DEV_MAC,
	input wire logic RX_DONE,
	input wire logic RX_ERR,
	input wire logic [47:0] RX_DST_MAC,
	input wire logic [47:0] RX_SRC_MAC,
	input wire logic [15:0] RX_ETYPE,
	input wire logic [127:0] RX_IP6_SRC,
	input wire logic [127:0] RX_IP6_DST,
	input wire logic [7:0] RX_HOP_LIMIT,
	input wire logic [7:0] RX_LAST_NH,
	input wire logic [7:0] RX_ICMP_TYPE,
	input wire logic [7:0] RX_ICMP_CODE,
	input wire logic [127:0] RX_ND_TARGET,
	input wire logic RX_CSUM_OK,
	input wire logic RX_ND_VALID,
	input wire logic [15:0] RX_ARP_HTYPE,
	input wire logic [15:0] RX_ARP_PTYPE,
	input wire logic [7:0] RX_ARP_HLEN,
	input wire logic [7:0] RX_ARP_PLEN,
	input wire logic [15:0] RX_ARP_OP,
	input wire logic [47:0] RX_ARP_SHA,
	input wire logic [31:0] RX_RESOLVE_SENDER_IP_MATCH,
	input wire logic [31:0] RX_RESOLVE_TARGET_IP_MATCH,
	output logic NA_VALID,
	input wire logic NA_TAKE,
	output logic [47:0] NA_ETH_DST,
	output logic [47:0] NA_ETH_SRC,
	output logic [127:0] NA_IP_SRC,
	output logic [127:0] NA_IP_DST,
	output logic [7:0] NA_HOP,
	output logic [31:0] NA_FLAGS,
	output logic [127:0] NA_TARGET,
	output logic [15:0] NA_CSUM,
	output logic ARP_VALID,
	input wire logic ARP_TAKE,
	output logic [47:0] ARP_ETH_DST,
	output logic [47:0] ARP_SHA,
	output logic [31:0] RESOLVE_SENDER_IP_MATCH_OUT,
	output logic [47:0] ARP_THA,
	output logic [31:0] RESOLVE_TARGET_IP_MATCH_OUT,
	output logic [15:0] ARP_OPCODE
);
	import nsaor_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0][3:0][127:0] nbr; // Set, then dest/src/target a/target b
		logic [31:0] spa;
		logic [31:0] tpa;
		logic nbr_en;
		logic arp_en;
		logic src_sel;
		logic res_clr;
		logic nbr_seen;
		logic arp_seen;
		logic susp_q;
		logic [31:0] rdata;
		logic na_valid;
		logic [47:0] na_eth_dst;
		logic [47:0] na_eth_src;
		logic [127:0] na_ip_src;
		logic [127:0] na_ip_dst;
		logic [7:0] na_hop;
		logic [31:0] na_flags;
		logic [127:0] na_target;
		logic [15:0] na_csum;
		logic arp_valid;
		logic [47:0] arp_eth_dst;
		logic [47:0] arp_sha;
		logic [31:0] resolve_sender_ip_match;
		logic [47:0] arp_tha;
		logic [31:0] resolve_target_ip_match;
	} nsaor_state_t;

	nsaor_state_t st;
	nsaor_state_t next_st;
	logic ns_frame;
	logic arp_frame;
	logic snm;
	logic [1:0] hit;

	// One's-complement checksum over pseudo-header and advertisement body
	function automatic logic [15:0] nsaor_csum(input logic [127:0] s, input logic [127:0] d,
		input logic [127:0] t, input logic [47:0] m, input logic [15:0] fl);
		logic [31:0] acc;
		acc = 32'(NSAOR_NA_LEN) + 32'(NSAOR_NH_ICMP6) + 32'({NSAOR_ICMP_NA, 8'h00}) + 32'(fl)
			+ 32'(NSAOR_OPT_TLLA);
		for (int i = 0; i < 8; i++) begin
			acc = acc + 32'(s[i*16+:16]) + 32'(d[i*16+:16]) + 32'(t[i*16+:16]);
		end
		for (int i = 0; i < 3; i++) begin
			acc = acc + 32'(m[i*16+:16]);
		end
		acc = 32'(acc[15:0]) + 32'(acc[31:16]);
		acc = 32'(acc[15:0]) + 32'(acc[31:16]);
		return ~acc[15:0];
	endfunction

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		logic [4:0] idx;
		logic dst_ok;
		logic src_ok;
		logic na_go;
		logic arp_go;
		logic own;
		logic leave;
		logic [127:0] dreg;
		logic [127:0] rsp_dst;
		logic solicited;
		idx = ADDR[6:2];
		dst_ok = 1'b0;
		src_ok = 1'b0;
		dreg = '0;
		na_go = 1'b0;
		arp_go = 1'b0;
		rsp_dst = '0;
		solicited = 1'b0;
		next_st = st;
		hit = 2'b00;
		own = (RX_DST_MAC == DEV_MAC);
		leave = st.susp_q && !SUSPEND;
		next_st.susp_q = SUSPEND;
		// Solicited-node multicast destinations compare on their low bytes
		snm = (RX_IP6_DST[127:24] == NSAOR_SNM_PREFIX);
		for (int s = 0; s < 2; s++) begin
			dst_ok = (snm ? (RX_IP6_DST[23:0] == st.nbr[s][0][127:104])
				: (RX_IP6_DST == st.nbr[s][0])) || (RX_IP6_DST == st.nbr[s][2])
				|| (RX_IP6_DST == st.nbr[s][3]);
			src_ok = (st.nbr[s][1] == '0) || (RX_IP6_SRC == st.nbr[s][1]);
			hit[s] = dst_ok && src_ok
				&& ((RX_ND_TARGET == st.nbr[s][2]) || (RX_ND_TARGET == st.nbr[s][3]));
		end
		dreg = hit[0] ? st.nbr[0][0] : st.nbr[1][0];
		// Qualify solicitations; the frame itself is only observed
		ns_frame = RX_DONE && st.nbr_en && (own || RX_DST_MAC[NSAOR_MC_BIT])
			&& (RX_ETYPE == NSAOR_ET_IPV6) && (RX_LAST_NH == NSAOR_NH_ICMP6)
			&& (RX_ICMP_TYPE == NSAOR_ICMP_NS) && (RX_ICMP_CODE == 8'h00);
		na_go = ns_frame && (|hit) && RX_CSUM_OK && !RX_ERR
			&& RX_ND_VALID && (RX_HOP_LIMIT == NSAOR_HOP_MAX)
			&& (!st.na_valid || NA_TAKE);
		// Qualify address-resolution requests
		arp_frame = RX_DONE && st.arp_en && (own || (RX_DST_MAC == '1))
			&& (RX_ETYPE == NSAOR_ET_ARP) && (RX_ARP_HTYPE == NSAOR_ARP_HTYPE)
			&& (RX_ARP_PTYPE == NSAOR_ARP_PTYPE) && (RX_ARP_HLEN == NSAOR_ARP_HLEN)
			&& (RX_ARP_PLEN == NSAOR_ARP_PLEN) && (RX_ARP_OP == NSAOR_ARP_OP_REQ);
		arp_go = arp_frame && !RX_ERR && (RX_RESOLVE_SENDER_IP_MATCH == st.spa) && (RX_RESOLVE_TARGET_IP_MATCH == st.tpa)
			&& (!st.arp_valid || ARP_TAKE);
		// Register writes; seen bits are write-one-to-clear
		if (WE) begin
			if (ADDR <= NSAOR_NBR_LAST) begin
				next_st.nbr[idx[4]][idx[3:2]][idx[1:0]*32+:32] = WDATA;
			end
			if (ADDR == NSAOR_SPA_ADDR) begin
				next_st.spa = WDATA;
			end
			if (ADDR == NSAOR_TPA_ADDR) begin
				next_st.tpa = WDATA;
			end
			if (ADDR == NSAOR_WAKE2_ADDR) begin
				next_st.nbr_en = WDATA[NSAOR_B_NBR_EN];
				next_st.arp_en = WDATA[NSAOR_B_ARP_EN];
				next_st.src_sel = WDATA[NSAOR_B_SRC_SEL];
				if (WDATA[NSAOR_B_NBR_SEEN]) begin
					next_st.nbr_seen = 1'b0;
				end
				if (WDATA[NSAOR_B_ARP_SEEN]) begin
					next_st.arp_seen = 1'b0;
				end
			end
			if (ADDR == NSAOR_PMT_ADDR) begin
				next_st.res_clr = WDATA[NSAOR_B_RES_CLR];
			end
		end
		// Leaving suspend may wipe the seen bits
		if (leave && st.res_clr) begin
			next_st.nbr_seen = 1'b0;
			next_st.arp_seen = 1'b0;
		end
		// Hardware sets win over any clear in the same cycle
		if (ns_frame) begin
			next_st.nbr_seen = 1'b1;
		end
		if (arp_frame) begin
			next_st.arp_seen = 1'b1;
		end
		// Read data, one cycle after the strobe
		if (RE) begin
			next_st.rdata = NSAOR_RST_WORD;
			if (ADDR <= NSAOR_NBR_LAST) begin
				next_st.rdata = st.nbr[idx[4]][idx[3:2]][idx[1:0]*32+:32];
			end
			if (ADDR == NSAOR_SPA_ADDR) begin
				next_st.rdata = st.spa;
			end
			if (ADDR == NSAOR_TPA_ADDR) begin
				next_st.rdata = st.tpa;
			end
			if (ADDR == NSAOR_WAKE2_ADDR) begin
				next_st.rdata[NSAOR_B_NBR_EN] = st.nbr_en;
				next_st.rdata[NSAOR_B_ARP_EN] = st.arp_en;
				next_st.rdata[NSAOR_B_SRC_SEL] = st.src_sel;
				next_st.rdata[NSAOR_B_NBR_SEEN] = st.nbr_seen;
				next_st.rdata[NSAOR_B_ARP_SEEN] = st.arp_seen;
			end
			if (ADDR == NSAOR_PMT_ADDR) begin
				next_st.rdata[NSAOR_B_RES_CLR] = st.res_clr;
			end
		end
		// Reply hand-off to the transmitter
		if (NA_TAKE) begin
			next_st.na_valid = 1'b0;
		end
		if (ARP_TAKE) begin
			next_st.arp_valid = 1'b0;
		end
		// Build the advertisement; no wake output exists at all
		rsp_dst = (RX_IP6_SRC == '0) ? NSAOR_ALL_NODES : RX_IP6_SRC;
		solicited = (rsp_dst != NSAOR_ALL_NODES);
		if (na_go) begin
			next_st.na_valid = 1'b1;
			next_st.na_eth_dst = RX_SRC_MAC;
			next_st.na_eth_src = DEV_MAC;
			next_st.na_ip_src = st.src_sel ? dreg : RX_ND_TARGET;
			next_st.na_ip_dst = rsp_dst;
			next_st.na_hop = NSAOR_HOP_MAX;
			next_st.na_flags = {1'b0, solicited, 1'b1, 29'h0000_0000};
			next_st.na_target = RX_ND_TARGET;
			next_st.na_csum = nsaor_csum(st.src_sel ? dreg : RX_ND_TARGET, rsp_dst,
				RX_ND_TARGET, DEV_MAC, {1'b0, solicited, 1'b1, 13'h0000});
		end
		// Build the address-resolution reply
		if (arp_go) begin
			next_st.arp_valid = 1'b1;
			next_st.arp_eth_dst = RX_SRC_MAC;
			next_st.arp_sha = DEV_MAC;
			next_st.resolve_sender_ip_match = RX_RESOLVE_TARGET_IP_MATCH;
			next_st.arp_tha = RX_ARP_SHA;
			next_st.resolve_target_ip_match = RX_RESOLVE_SENDER_IP_MATCH;
		end
	end

	// State register
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state register, except ARP_OPCODE, which is the constant reply opcode
	assign RDATA = st.rdata;
	assign NA_VALID = st.na_valid;
	assign NA_ETH_DST = st.na_eth_dst;
	assign NA_ETH_SRC = st.na_eth_src;
	assign NA_IP_SRC = st.na_ip_src;
	assign NA_IP_DST = st.na_ip_dst;
	assign NA_HOP = st.na_hop;
	assign NA_FLAGS = st.na_flags;
	assign NA_TARGET = st.na_target;
	assign NA_CSUM = st.na_csum;
	assign ARP_VALID = st.arp_valid;
	assign ARP_ETH_DST = st.arp_eth_dst;
	assign ARP_SHA = st.arp_sha;
	assign RESOLVE_SENDER_IP_MATCH_OUT = st.resolve_sender_ip_match;
	assign ARP_THA = st.arp_tha;
	assign RESOLVE_TARGET_IP_MATCH_OUT = st.resolve_target_ip_match;
	assign ARP_OPCODE = NSAOR_ARP_OP_REP;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);

	chk_na_needs_enable: assert property ($rose(NA_VALID) |-> $past(st.nbr_en) && $past(ns_frame))
		else $error("advertisement without enabled solicitation");
	chk_na_dest_choice: assert property ($rose(NA_VALID) |-> NA_IP_DST ==
		(($past(RX_IP6_SRC) == '0) ? NSAOR_ALL_NODES : $past(RX_IP6_SRC)))
		else $error("advertisement destination wrong");
	chk_na_flag_word: assert property (NA_VALID |-> NA_FLAGS[31] == 1'b0 && NA_FLAGS[29]
		&& NA_FLAGS[28:0] == '0 && NA_FLAGS[30] == (NA_IP_DST != NSAOR_ALL_NODES) && NA_HOP == NSAOR_HOP_MAX)
		else $error("advertisement flags or hop limit wrong");
	chk_na_src_sel: assert property ($rose(NA_VALID) && !$past(st.src_sel) |-> NA_IP_SRC == NA_TARGET)
		else $error("advertisement source not target");
	chk_na_held: assert property (NA_VALID && !NA_TAKE |=> NA_VALID && $stable(NA_TARGET))
		else $error("pending advertisement changed");
	chk_na_rejects_err: assert property (RX_ERR && !NA_VALID |=> !NA_VALID)
		else $error("reply to errored frame");
	chk_arp_swap: assert property ($rose(ARP_VALID) |-> ARP_THA == $past(RX_ARP_SHA)
		&& RESOLVE_SENDER_IP_MATCH_OUT == $past(RX_RESOLVE_TARGET_IP_MATCH) && RESOLVE_TARGET_IP_MATCH_OUT == $past(RX_RESOLVE_SENDER_IP_MATCH) && ARP_SHA == $past(DEV_MAC))
		else $error("address reply fields wrong");
	chk_arp_match: assert property ($rose(ARP_VALID) |-> $past(RX_RESOLVE_SENDER_IP_MATCH) == $past(st.spa)
		&& $past(RX_RESOLVE_TARGET_IP_MATCH) == $past(st.tpa) && $past(arp_frame))
		else $error("address reply without match");
	chk_ns_seen: assert property (ns_frame |=> st.nbr_seen ##1 (st.nbr_seen || $past(WE)
		|| ($past(st.susp_q) && !$past(SUSPEND))))
		else $error("solicitation seen bit not set");
	chk_arp_seen: assert property (arp_frame |=> st.arp_seen)
		else $error("address request seen bit not set");

	cov_na_sent: cover property ($rose(NA_VALID) ##[1:20] NA_TAKE);
	cov_arp_sent: cover property ($rose(ARP_VALID) ##[1:20] ARP_TAKE);
	cov_snm_hit: cover property (ns_frame && snm && (|hit));
	cov_resume_clear: cover property (st.nbr_seen ##1 !st.nbr_seen && !SUSPEND);
endmodule // nsaor_responder

// [bench/nsaor_mac_model.sv]
/*
 * Transmit side of the MAC as seen by the offload responder: takes each
 * pending reply after a programmable gap, as if waiting for a frame end.
 * Assumes one clock shared with the responder and an active-high reset.
 */
module nsaor_mac_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] dly,
	input wire logic na_valid,
	input wire logic arp_valid,
	output logic na_take,
	output logic arp_take
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] na_cnt;
	logic [3:0] arp_cnt;
	// --------------------------------------------------------------
	// Take pulses
	// --------------------------------------------------------------
	// One pulse per pending reply, only after the gap has run out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{na_take, arp_take, na_cnt, arp_cnt} <= '0;
		end else begin
			na_take <= 1'b0;
			arp_take <= 1'b0;
			if (na_valid && !na_take) begin
				na_take <= (na_cnt >= dly);
				na_cnt <= (na_cnt >= dly) ? 4'h0 : na_cnt + 4'h1;
			end
			if (arp_valid && !arp_take) begin
				arp_take <= (arp_cnt >= dly);
				arp_cnt <= (arp_cnt >= dly) ? 4'h0 : arp_cnt + 4'h1;
			end
		end
	end
endmodule // nsaor_mac_model

// [bench/nsaor_responder_test.sv]
/*
 * Self-checking bench for the offload responder: register tasks, frame
 * summaries with faults injected, and checks of the queued replies.
 * Assumes the transmit model in nsaor_mac_model and the package constants.
 */
module nsaor_responder_test;
	timeunit 1ns;
	timeprecision 1ps;
	import nsaor_pkg::*;
	localparam logic [47:0] DMAC = 48'h02AA_BBCC_DD01, SMAC = 48'h0211_2233_4455, AMAC = 48'h0266_7788_99AA;
	localparam logic [127:0] SIP = 128'hFE80_0000_0000_0000_0211_22FF_FE33_4455;
	localparam logic [127:0] D0 = 128'h2001_0DB8_0000_0000_0000_0000_0000_0A01, T0 = 128'h2001_0DB8_0000_0000_0000_0000_0000_0B02;
	localparam logic [127:0] D1 = 128'hFD00_0000_0000_0000_0000_0000_0000_0C03, T1 = 128'hFD00_0000_0000_0000_0000_0000_0000_0D04;
	localparam logic [127:0] S1 = 128'hFD00_0000_0000_0000_0000_0000_0000_0E05;
	localparam logic [31:0] SPA0 = 32'hC0A8_0001, TPA0 = 32'hC0A8_0002;
	logic MCLK, RESET, WE, RE, SUSPEND, RX_DONE, RX_ERR, RX_CSUM_OK, RX_ND_VALID, NA_VALID, NA_TAKE, ARP_VALID, ARP_TAKE;
	logic [7:0] ADDR, RX_HOP_LIMIT, RX_LAST_NH, RX_ICMP_TYPE, RX_ICMP_CODE, RX_ARP_HLEN, RX_ARP_PLEN, NA_HOP;
	logic [15:0] RX_ETYPE, RX_ARP_HTYPE, RX_ARP_PTYPE, RX_ARP_OP, NA_CSUM, ARP_OPCODE;
	logic [31:0] WDATA, RDATA, RX_RESOLVE_SENDER_IP_MATCH, RX_RESOLVE_TARGET_IP_MATCH, NA_FLAGS, RESOLVE_SENDER_IP_MATCH_OUT, RESOLVE_TARGET_IP_MATCH_OUT;
	logic [47:0] DEV_MAC, RX_DST_MAC, RX_SRC_MAC, RX_ARP_SHA, NA_ETH_DST, NA_ETH_SRC, ARP_ETH_DST, ARP_SHA, ARP_THA;
	logic [127:0] RX_IP6_SRC, RX_IP6_DST, RX_ND_TARGET, NA_IP_SRC, NA_IP_DST, NA_TARGET;
	logic [3:0] tx_delay;
	int n_mismatch = 0;
	int check_count = 0;
	nsaor_responder uut (.*);
	nsaor_mac_model mac (.clk(MCLK), .rst(RESET), .dly(tx_delay), .na_valid(NA_VALID), .arp_valid(ARP_VALID),
		.na_take(NA_TAKE), .arp_take(ARP_TAKE));
	// --------------------------------------------------------------
	// Clock and shared tasks
	// --------------------------------------------------------------
	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge MCLK);
		ADDR <= a;
		WDATA <= d;
		WE <= 1'b1;
		@(posedge MCLK);
		WE <= 1'b0;
	endtask
	// Read strobe for one cycle, data compared in the cycle after it
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge MCLK);
		ADDR <= a;
		RE <= 1'b1;
		@(posedge MCLK);
		RE <= 1'b0;
		@(negedge MCLK);
		chk($sformatf("read %h", a), 128'(e), 128'(RDATA));
	endtask
	task automatic wr128(input int s, input int r, input logic [127:0] v);
		for (int w = 0; w < 4; w++) wr(8'(64 * s + 16 * r + 4 * w), v[32 * w +: 32]);
	endtask
	// Frame summary: f selects the frame kind and the injected fault
	task automatic rx(input int f);
		@(posedge MCLK);
		RX_DST_MAC <= (f == 6) ? DMAC ^ 48'h1 : (f == 22) ? 48'h0100_5E00_0001 : (f >= 20) ? '1 : DMAC;
		RX_SRC_MAC <= SMAC;
		RX_ETYPE <= (f >= 20) ? NSAOR_ET_ARP : NSAOR_ET_IPV6;
		RX_ERR <= (f == 2);
		RX_CSUM_OK <= (f != 1);
		RX_ND_VALID <= (f != 8);
		RX_IP6_SRC <= (f == 12) ? '0 : (f == 13) ? S1 : SIP;
		RX_IP6_DST <= (f == 12) ? {NSAOR_SNM_PREFIX, D0[127:104]} : (f == 11 || f == 13) ? D1 : (f == 10) ? ~D0 : D0;
		RX_HOP_LIMIT <= (f == 4) ? 8'hFE : NSAOR_HOP_MAX;
		RX_LAST_NH <= (f == 7) ? 8'h11 : NSAOR_NH_ICMP6;
		RX_ICMP_TYPE <= (f == 3) ? NSAOR_ICMP_NA : NSAOR_ICMP_NS;
		RX_ICMP_CODE <= (f == 9) ? 8'h01 : 8'h00;
		RX_ND_TARGET <= (f == 5) ? D0 : (f == 11 || f == 13) ? T1 : T0;
		RX_ARP_HTYPE <= NSAOR_ARP_HTYPE;
		RX_ARP_PTYPE <= (f == 24) ? NSAOR_ET_IPV6 : NSAOR_ARP_PTYPE;
		RX_ARP_HLEN <= NSAOR_ARP_HLEN;
		RX_ARP_PLEN <= NSAOR_ARP_PLEN;
		RX_ARP_OP <= (f == 21) ? NSAOR_ARP_OP_REP : NSAOR_ARP_OP_REQ;
		RX_ARP_SHA <= AMAC;
		RX_RESOLVE_SENDER_IP_MATCH <= SPA0;
		RX_RESOLVE_TARGET_IP_MATCH <= (f == 23) ? TPA0 ^ 32'h1 : TPA0;
		RX_DONE <= 1'b1;
		@(posedge MCLK);
		RX_DONE <= 1'b0;
	endtask
	task automatic quiet(input int f);
		rx(f);
		@(negedge MCLK);
		chk($sformatf("no reply for frame %0d", f), 128'h0, 128'({NA_VALID, ARP_VALID}));
	endtask
	// Reply must be pending, then must fall once the transmitter takes it
	task automatic settle(input logic v, input logic [47:0] edst);
		int i;
		chk("reply pending", 128'h1, 128'(v));
		chk("reply eth dst", 128'(SMAC), 128'(edst));
		for (i = 0; i < 16 && (NA_VALID === 1'b1 || ARP_VALID === 1'b1); i++) @(negedge MCLK);
		if (i == 16) begin
			n_mismatch++;
			$display("mismatch reply release expected 0 seen 1");
			complete_run();
		end
	endtask
	// Reference checksum: pseudo-header, then the advertisement as it goes on the wire
	function automatic logic [15:0] ref_csum(input logic [127:0] s, input logic [127:0] d, input logic [31:0] fl,
		input logic [127:0] t);
		logic [575:0] msg;
		logic [31:0] acc;
		msg = {s, d, 32'h0000_0020, 24'h00_0000, 8'h3A, 8'h88, 8'h00, 16'h0000, fl, t, 8'h02, 8'h01, DMAC};
		acc = 32'h0000_0000;
		for (int i = 0; i < 36; i++) acc = acc + 32'(msg[16 * i +: 16]);
		acc = 32'(acc[15:0]) + 32'(acc[31:16]);
		acc = 32'(acc[15:0]) + 32'(acc[31:16]);
		return ~acc[15:0];
	endfunction
	task automatic na_chk(input logic [127:0] src, input logic [127:0] dst, input logic [31:0] fl, input logic [127:0] tg);
		@(negedge MCLK);
		chk("advert eth src", 128'(DEV_MAC), 128'(NA_ETH_SRC));
		chk("advert ip src", src, NA_IP_SRC);
		chk("advert ip dst", dst, NA_IP_DST);
		chk("advert hop", 128'(NSAOR_HOP_MAX), 128'(NA_HOP));
		chk("advert flags", 128'(fl), 128'(NA_FLAGS));
		chk("advert target", tg, NA_TARGET);
		chk("advert csum", 128'(ref_csum(src, dst, fl, tg)), 128'(NA_CSUM));
		settle(NA_VALID, NA_ETH_DST);
	endtask
	// --------------------------------------------------------------
	// Tests
	// --------------------------------------------------------------
	initial begin
		{ADDR, WDATA, WE, RE, SUSPEND, RX_DONE, RX_ERR, RX_DST_MAC, RX_SRC_MAC, RX_ETYPE, RX_IP6_SRC, RX_IP6_DST} = '0;
		{RX_HOP_LIMIT, RX_LAST_NH, RX_ICMP_TYPE, RX_ICMP_CODE, RX_ND_TARGET, RX_CSUM_OK, RX_ND_VALID} = '0;
		{RX_ARP_HTYPE, RX_ARP_PTYPE, RX_ARP_HLEN, RX_ARP_PLEN, RX_ARP_OP, RX_ARP_SHA, RX_RESOLVE_SENDER_IP_MATCH, RX_RESOLVE_TARGET_IP_MATCH} = '0;
		DEV_MAC = DMAC;
		tx_delay = 4'h3;
		RESET = 1'b1;
		repeat (5) @(posedge MCLK);
		RESET <= 1'b0;
		chk_rd(NSAOR_WAKE2_ADDR, NSAOR_RST_WORD);
		wr(NSAOR_SPA_ADDR, SPA0);
		wr(NSAOR_TPA_ADDR, TPA0);
		wr(8'h90, 32'hFFFF_FFFF);
		chk_rd(NSAOR_SPA_ADDR, SPA0);
		chk_rd(8'h90, 32'h0);
		wr128(0, 0, D0);
		wr128(0, 3, T0);
		wr128(1, 0, D1);
		wr128(1, 1, S1);
		wr128(1, 2, T1);
		chk_rd(8'h40, D1[31:0]);
		quiet(0);
		chk_rd(NSAOR_WAKE2_ADDR, 32'h0);
		$display("test registers done");
		wr(NSAOR_WAKE2_ADDR, 32'h0000_0001);
		rx(0);
		na_chk(T0, SIP, 32'h6000_0000, T0);
		chk_rd(NSAOR_WAKE2_ADDR, 32'h0000_0101);
		rx(13);
		na_chk(T1, S1, 32'h6000_0000, T1);
		wr(NSAOR_WAKE2_ADDR, 32'h0000_0105);
		rx(12);
		na_chk(D0, NSAOR_ALL_NODES, 32'h2000_0000, T0);
		chk_rd(NSAOR_WAKE2_ADDR, 32'h0000_0105);
		wr(NSAOR_WAKE2_ADDR, 32'h0000_0001);
		for (int f = 1; f <= 11; f++) quiet(f);
		$display("test neighbour done");
		wr(NSAOR_WAKE2_ADDR, 32'h0000_0102);
		quiet(0);
		quiet(22);
		chk_rd(NSAOR_WAKE2_ADDR, 32'h0000_0002);
		rx(20);
		@(negedge MCLK);
		chk("resolve sha", 128'(DEV_MAC), 128'(ARP_SHA));
		chk("resolve spa", 128'(TPA0), 128'(RESOLVE_SENDER_IP_MATCH_OUT));
		chk("resolve tha", 128'(AMAC), 128'(ARP_THA));
		chk("resolve tpa", 128'(SPA0), 128'(RESOLVE_TARGET_IP_MATCH_OUT));
		chk("resolve op", 128'(NSAOR_ARP_OP_REP), 128'(ARP_OPCODE));
		settle(ARP_VALID, ARP_ETH_DST);
		for (int f = 21; f <= 24; f++) quiet(f);
		chk_rd(NSAOR_WAKE2_ADDR, 32'h0000_0202);
		$display("test resolve done");
		wr(NSAOR_PMT_ADDR, 32'h0000_0001);
		chk_rd(NSAOR_PMT_ADDR, 32'h0000_0001);
		// Host clears status and enables both offloads before suspending
		wr(NSAOR_WAKE2_ADDR, 32'h0000_0303);
		chk_rd(NSAOR_WAKE2_ADDR, 32'h0000_0003);
		@(posedge MCLK);
		SUSPEND <= 1'b1;
		quiet(1);
		quiet(23);
		chk_rd(NSAOR_WAKE2_ADDR, 32'h0000_0303);
		@(posedge MCLK);
		SUSPEND <= 1'b0;
		chk_rd(NSAOR_WAKE2_ADDR, 32'h0000_0003);
		// Host drops every enable on return to normal operation
		wr(NSAOR_WAKE2_ADDR, 32'h0000_0000);
		chk_rd(NSAOR_WAKE2_ADDR, 32'h0000_0000);
		$display("test resume done");
		complete_run();
	end
endmodule // nsaor_responder_test
